// *** dv/ipa_addr_gen_tb_top.sv ***
// Self-checking testbench of the indirect pointer address generator
`timescale 1ns/1ps
module ipa_addr_gen_tb_top;
	logic clk = 1'h0;
	logic arst_n = 1'h0;
	logic req_valid = 1'h0;
	logic [1:0] req_form = 2'h0;
	logic req_wide = 1'h0;
	logic [2:0] req_sel = 3'h0;
	logic req_circ = 1'h0;
	logic [15:0] req_bs = 16'h0000;
	logic load_valid = 1'h0;
	logic [2:0] load_sel = 3'h0;
	logic [22:0] load_data = 23'h000000;
	logic rd_valid, ready, addr_valid, addr_second, fault;
	logic [15:0] rd_data, temp_two, temp_three;
	logic [22:0] addr;
	int n_errors = 0;
	int samples_checked = 0;

	// Free running clock
	always #4 clk = ~clk;

	ipa_addr_gen u_ipa_addr_gen (.CLK_IN(clk), .ARST_N_IN(arst_n), .REQ_VALID_IN(req_valid),
		.REQ_FORM_IN(req_form), .REQ_WIDE_IN(req_wide), .REQ_PTR_SEL_IN(req_sel), .REQ_CIRC_IN(req_circ),
		.REQ_BUF_START_IN(req_bs), .LOAD_VALID_IN(load_valid), .LOAD_SEL_IN(load_sel),
		.LOAD_DATA_IN(load_data), .RD_VALID_IN(rd_valid), .RD_DATA_IN(rd_data), .READY_OUT(ready),
		.ADDR_OUT(addr), .ADDR_VALID_OUT(addr_valid), .ADDR_SECOND_OUT(addr_second), .FAULT_OUT(fault),
		.TEMP_TWO_OUT(temp_two), .TEMP_THREE_OUT(temp_three));
	ipa_mmr_model u_ipa_mmr_model (.clk_in(clk), .arst_n_in(arst_n), .addr_valid_in(addr_valid),
		.addr_in(addr), .rd_valid_out(rd_valid), .rd_data_out(rd_data));

	// Verdict and end of run
	task automatic conclude();
		$display("Counts: %0d compared, %0d mismatched", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic load(input logic [2:0] sel, input logic [22:0] val);
		@(posedge clk);
		load_valid <= 1'h1;
		load_sel <= sel;
		load_data <= val;
		@(posedge clk);
		load_valid <= 1'h0;
	endtask

	// One access: checks fault, the first address and for wide the second, marker and the words landed in the temps
	task automatic access(input logic [1:0] form, input logic wide, input logic [2:0] sel, input logic circ,
		input logic [15:0] bs, input logic [22:0] ea, input logic efault);
		int i;
		logic [22:0] ea2;
		ea2 = ea[0] ? ea - 23'h000001 : ea + 23'h000001;
		@(posedge clk);
		req_valid <= 1'h1;
		req_form <= form;
		req_wide <= wide;
		req_sel <= sel;
		req_circ <= circ;
		req_bs <= bs;
		@(posedge clk);
		req_valid <= 1'h0;
		i = 0;
		do begin
			@(posedge clk);
			#1;
			i++;
		end while (addr_valid !== 1'h1 && fault !== 1'h1 && i < 8);
		if (i >= 8) begin
			n_errors++;
			$display("Error at %0t: no answer to access", $time);
			conclude();
		end
		cmp(fault, efault, "fault");
		if (!efault) begin
			cmp(addr, ea, "first address");
			cmp(addr_second, 1'h0, "first marker");
			if (wide) begin
				@(posedge clk);
				#1;
				cmp({addr_valid, addr_second}, 2'h3, "second strobe");
				cmp(addr, ea2, "second address");
			end
			cmp(ready, 1'h1, "ready after last address");
			@(posedge clk);
			@(posedge clk);
			#1;
			cmp(temp_two, ea[15:0] ^ 16'h5A3C, "first word");
			if (wide) begin
				cmp(temp_three, ea2[15:0] ^ 16'h5A3C, "paired word");
			end
		end else begin
			@(posedge clk);
			#1;
			cmp({fault, addr_valid}, 2'h0, "fault pulse width");
		end
	endtask

	// Reads a pointer back through a plain short access
	task automatic peek(input logic [2:0] sel, input logic [22:0] exp);
		access(2'h0, 1'h0, sel, 1'h0, 16'h0000, exp, exp == 23'h000000);
	endtask

	task automatic t_reset();
		cmp({ready, addr_valid, addr_second, fault}, 4'h8, "reset outputs");
		cmp({temp_two, temp_three}, 32'h0, "reset temps");
		peek(3'h7, 23'h000000);
		$display("Test reset done");
	endtask

	task automatic t_forms();
		logic [22:0] base, ea, np;
		logic [15:0] st;
		for (int b = 0; b < 2; b++) begin
			for (int f = 0; f < 4; f++) begin
				for (int w = 0; w < 2; w++) begin
					base = 23'h051234 + b;
					st = w ? 16'h0002 : 16'h0001;
					ea = {base[22:16], (f == 3) ? base[15:0] + st : base[15:0]};
					np = (f == 0) ? base : {base[22:16], (f == 2) ? base[15:0] - st : base[15:0] + st};
					load(3'h3, base);
					access(f[1:0], w[0], 3'h3, 1'h0, 16'h0000, ea, 1'h0);
					peek(3'h3, np);
				end
			end
		end
		$display("Test forms done");
	endtask

	task automatic t_edges();
		load(3'h5, 23'h030000);
		access(2'h2, 1'h0, 3'h5, 1'h0, 16'h0000, 23'h030000, 1'h0);
		peek(3'h5, 23'h03FFFF);
		access(2'h1, 1'h1, 3'h5, 1'h0, 16'h0000, 23'h03FFFF, 1'h0);
		peek(3'h5, 23'h030001);
		load(3'h6, 23'h020010);
		access(2'h1, 1'h0, 3'h6, 1'h1, 16'h0100, 23'h020110, 1'h0);
		peek(3'h6, 23'h020011);
		access(2'h3, 1'h0, 3'h6, 1'h1, 16'h0100, 23'h020112, 1'h0);
		peek(3'h6, 23'h020012);
		$display("Test edges done");
	endtask

	task automatic t_fault();
		load(3'h1, 23'h000000);
		access(2'h0, 1'h0, 3'h1, 1'h0, 16'h0000, 23'h000000, 1'h1);
		load(3'h2, 23'h000001);
		access(2'h0, 1'h1, 3'h2, 1'h0, 16'h0000, 23'h000001, 1'h1);
		peek(3'h2, 23'h000001);
		load(3'h4, 23'h00FFFF);
		access(2'h3, 1'h0, 3'h4, 1'h0, 16'h0000, 23'h000000, 1'h1);
		peek(3'h4, 23'h00FFFF);
		$display("Test fault done");
	endtask

	task automatic t_loads();
		@(posedge clk);
		load_valid <= 1'h1;
		load_sel <= 3'h0;
		load_data <= 23'h7F0040;
		@(posedge clk);
		load_sel <= 3'h7;
		load_data <= 23'h000013;
		@(posedge clk);
		load_valid <= 1'h0;
		peek(3'h0, 23'h7F0040);
		peek(3'h7, 23'h000013);
		$display("Test loads done");
	endtask

	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		arst_n <= 1'h1;
		@(posedge clk);
		#1;
		t_reset();
		t_forms();
		t_edges();
		t_fault();
		t_loads();
		conclude();
	end
endmodule

// *** dv/ipa_mmr_model.sv ***
// Model of the register space that answers each word address
`timescale 1ns/1ps
module ipa_mmr_model (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic addr_valid_in,
	input wire logic [22:0] addr_in,
	output logic rd_valid_out,
	output logic [15:0] rd_data_out
);
	// Word for an address one cycle after it shows; idle bus inverts the last word each cycle, so the stale word returns every second idle cycle
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rd_valid_out <= 1'h0;
			rd_data_out <= 16'h0000;
		end else if (addr_valid_in) begin
			rd_valid_out <= 1'h1;
			rd_data_out <= addr_in[15:0] ^ 16'h5A3C;
		end else begin
			rd_valid_out <= 1'h0;
			rd_data_out <= ~rd_data_out;
		end
	end
endmodule

// *** verilog/ipa_addr_gen.sv ***
// Indirect pointer address generator for memory-mapped register accesses
`timescale 1ns/1ps
module ipa_addr_gen (
	input wire logic CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic REQ_VALID_IN,
	input wire logic [1:0] REQ_FORM_IN,
	input wire logic REQ_WIDE_IN,
	input wire logic [2:0] REQ_PTR_SEL_IN,
	input wire logic REQ_CIRC_IN,
	input wire logic [15:0] REQ_BUF_START_IN,
	input wire logic LOAD_VALID_IN,
	input wire logic [2:0] LOAD_SEL_IN,
	input wire logic [22:0] LOAD_DATA_IN,
	input wire logic RD_VALID_IN,
	input wire logic [15:0] RD_DATA_IN,
	output logic READY_OUT,
	output logic [22:0] ADDR_OUT,
	output logic ADDR_VALID_OUT,
	output logic ADDR_SECOND_OUT,
	output logic FAULT_OUT,
	output logic [15:0] TEMP_TWO_OUT,
	output logic [15:0] TEMP_THREE_OUT
);
	ipa_pkg::ipa_state_t s_ff;
	ipa_pkg::ipa_state_t nxt_s;
	ipa_ptr_if pif ();

	logic [ipa_pkg::PTR_W-1:0] ptr;
	logic [ipa_pkg::LOW_W-1:0] step;
	logic [ipa_pkg::LOW_W-1:0] low_next;
	logic [ipa_pkg::LOW_W-1:0] eff_low;
	logic [ipa_pkg::LOW_W-1:0] base_low;
	logic [ipa_pkg::PTR_W-1:0] new_ptr;
	logic [ipa_pkg::PTR_W-1:0] first_addr;
	logic [ipa_pkg::PTR_W-1:0] second_addr;
	logic blocked;
	logic in_fetch;

	ipa_ptr_store u_store (
		.clk_in(CLK_IN),
		.arst_n_in(ARST_N_IN),
		.pif(pif.mem)
	);

	// Address arithmetic on the fetched pointer; only the low part steps
	always_comb begin
		ptr = pif.rd_data;
		step = ipa_pkg::step_of(s_ff.wide);
		if (s_ff.form == ipa_pkg::FORM_POST_DEC) begin
			low_next = ptr[15:0] - step;
		end else begin
			low_next = ptr[15:0] + step;
		end
		new_ptr = {ptr[22:16], low_next};
		eff_low = (s_ff.form == ipa_pkg::FORM_PRE_INC) ? low_next : ptr[15:0];
		base_low = s_ff.circ ? s_ff.buf_start + eff_low : eff_low;
		first_addr = {ptr[22:16], base_low};
		second_addr = ipa_pkg::pair_of(first_addr);
		blocked = (first_addr == ipa_pkg::ADDR_IRQ_ENABLE_LOW) ||
			(s_ff.wide && second_addr == ipa_pkg::ADDR_IRQ_ENABLE_LOW);
		in_fetch = (s_ff.st == ipa_pkg::ST_FETCH);
	end

	// Sequencer: take request, fetch pointer, issue one or two word addresses
	always_comb begin
		nxt_s = s_ff;
		nxt_s.addr_valid = 1'b0;
		nxt_s.addr_second = 1'b0;
		nxt_s.fault = 1'b0;
		pif.rd_en = 1'b0;
		pif.rd_sel = REQ_PTR_SEL_IN;
		pif.wr_en = 1'b0;
		pif.wr_sel = s_ff.sel;
		pif.wr_data = new_ptr;
		unique case (s_ff.st)
			ipa_pkg::ST_IDLE: begin
				if (s_ff.ready && LOAD_VALID_IN) begin
					pif.wr_en = 1'b1; // Pointer load wins over an access
					pif.wr_sel = LOAD_SEL_IN;
					pif.wr_data = LOAD_DATA_IN;
				end else if (s_ff.ready && REQ_VALID_IN) begin
					pif.rd_en = 1'b1;
					nxt_s.form = ipa_pkg::ipa_form_t'(REQ_FORM_IN);
					nxt_s.wide = REQ_WIDE_IN;
					nxt_s.sel = REQ_PTR_SEL_IN;
					nxt_s.circ = REQ_CIRC_IN;
					nxt_s.buf_start = REQ_BUF_START_IN;
					nxt_s.ready = 1'b0;
					nxt_s.st = ipa_pkg::ST_FETCH;
				end
			end
			ipa_pkg::ST_FETCH: begin
				if (blocked) begin
					nxt_s.fault = 1'b1;
					nxt_s.ready = 1'b1;
					nxt_s.st = ipa_pkg::ST_IDLE;
				end else begin
					nxt_s.addr = first_addr;
					nxt_s.addr_valid = 1'b1;
					nxt_s.second_addr = second_addr;
					pif.wr_en = (s_ff.form != ipa_pkg::FORM_PLAIN);
					nxt_s.ready = !s_ff.wide;
					nxt_s.st = s_ff.wide ? ipa_pkg::ST_SECOND : ipa_pkg::ST_IDLE;
				end
			end
			ipa_pkg::ST_SECOND: begin
				nxt_s.addr = s_ff.second_addr;
				nxt_s.addr_valid = 1'b1;
				nxt_s.addr_second = 1'b1;
				nxt_s.ready = 1'b1;
				nxt_s.st = ipa_pkg::ST_IDLE;
			end
			default: begin
				nxt_s.ready = 1'b1; // Unused state code falls back to idle
				nxt_s.st = ipa_pkg::ST_IDLE;
			end
		endcase
		// Read data one cycle after its address steers into the temp pair
		nxt_s.lag_valid = s_ff.addr_valid;
		nxt_s.lag_second = s_ff.addr_second;
		if (s_ff.lag_valid && RD_VALID_IN) begin
			if (s_ff.lag_second) begin
				nxt_s.temp_three = RD_DATA_IN;
			end else begin
				nxt_s.temp_two = RD_DATA_IN;
			end
		end
	end

	// State register
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			s_ff <= ipa_pkg::STATE_RESET;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Outputs straight from the state register
	assign READY_OUT = s_ff.ready;
	assign ADDR_OUT = s_ff.addr;
	assign ADDR_VALID_OUT = s_ff.addr_valid;
	assign ADDR_SECOND_OUT = s_ff.addr_second;
	assign FAULT_OUT = s_ff.fault;
	assign TEMP_TWO_OUT = s_ff.temp_two;
	assign TEMP_THREE_OUT = s_ff.temp_three;

	// Checks on the generated addresses and pointer updates
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!ARST_N_IN);

	sequence s_go(ipa_pkg::ipa_form_t f, logic w);
		in_fetch && !blocked && s_ff.form == f && s_ff.wide == w;
	endsequence

	sequence s_pair;
		ADDR_VALID_OUT && !ADDR_SECOND_OUT ##1 ADDR_VALID_OUT && ADDR_SECOND_OUT;
	endsequence

	a_plain_no_write: assert property (s_go(ipa_pkg::FORM_PLAIN, 1'b0) or s_go(ipa_pkg::FORM_PLAIN, 1'b1)
		|-> !pif.wr_en ##1 ADDR_VALID_OUT && (s_ff.circ || ADDR_OUT == $past(pif.rd_data)))
		else $error("plain form modified pointer");
	a_post_inc_short: assert property (s_go(ipa_pkg::FORM_POST_INC, 1'b0) |-> pif.wr_en &&
		pif.wr_data[15:0] == pif.rd_data[15:0] + 16'h0001 ##1 (s_ff.circ || ADDR_OUT == $past(pif.rd_data)))
		else $error("post increment short wrong");
	a_post_inc_wide: assert property (s_go(ipa_pkg::FORM_POST_INC, 1'b1) ##0 !s_ff.circ |->
		pif.wr_data[15:0] == pif.rd_data[15:0] + 16'h0002 ##1 s_pair)
		else $error("post increment wide wrong");
	a_post_dec_short: assert property (s_go(ipa_pkg::FORM_POST_DEC, 1'b0) |-> pif.wr_en &&
		pif.wr_data[15:0] == pif.rd_data[15:0] - 16'h0001 ##1 (s_ff.circ || ADDR_OUT == $past(pif.rd_data)))
		else $error("post decrement short wrong");
	a_post_dec_wide: assert property (s_go(ipa_pkg::FORM_POST_DEC, 1'b1) ##0 !s_ff.circ |->
		pif.wr_data[15:0] == pif.rd_data[15:0] - 16'h0002 ##1 ADDR_OUT == $past(pif.rd_data) ##1 ADDR_SECOND_OUT)
		else $error("post decrement wide wrong");
	a_pre_inc_short: assert property (s_go(ipa_pkg::FORM_PRE_INC, 1'b0) ##0 !s_ff.circ |->
		##1 ADDR_OUT[15:0] == $past(pif.rd_data[15:0]) + 16'h0001 && ADDR_OUT == $past(pif.wr_data))
		else $error("pre increment short wrong");
	a_pre_inc_wide: assert property (s_go(ipa_pkg::FORM_PRE_INC, 1'b1) ##0 !s_ff.circ |->
		pif.wr_data[15:0] == pif.rd_data[15:0] + 16'h0002 ##1 ADDR_OUT == $past(pif.wr_data)
		##1 ADDR_OUT == ($past(ADDR_OUT) ^ 23'h000001))
		else $error("pre increment wide wrong");
	a_pair_parity: assert property (ADDR_SECOND_OUT |-> $past(ADDR_VALID_OUT) &&
		ADDR_OUT == ($past(ADDR_OUT) ^ 23'h000001))
		else $error("second word address not paired");
	a_temp_steer: assert property (s_ff.lag_valid && RD_VALID_IN |->
		##1 ($past(s_ff.lag_second) ? TEMP_THREE_OUT : TEMP_TWO_OUT) == $past(RD_DATA_IN))
		else $error("read word landed in wrong temp");
	a_high_kept: assert property (in_fetch && pif.wr_en |-> pif.wr_data[22:16] == pif.rd_data[22:16])
		else $error("high pointer part changed");
	a_no_zero_addr: assert property (ADDR_VALID_OUT |-> ADDR_OUT != ipa_pkg::ADDR_IRQ_ENABLE_LOW)
		else $error("indirect access reached address zero");
	a_circ_base: assert property (in_fetch && !blocked && s_ff.circ && s_ff.form != ipa_pkg::FORM_PRE_INC |->
		##1 ADDR_OUT == {$past(pif.rd_data[22:16]), $past(pif.rd_data[15:0]) + $past(s_ff.buf_start)})
		else $error("circular base not applied");
endmodule

// *** verilog/ipa_pkg.sv ***
// Package of constants, types and helpers for the indirect pointer address generator
package ipa_pkg;
	localparam int PTR_W = 23;
	localparam int LOW_W = 16;
	localparam int HIGH_W = 7;
	localparam int DATA_W = 16;
	localparam int NUM_PTRS = 8;
	localparam int SEL_W = 3;
	localparam logic [LOW_W-1:0] STEP_SHORT = 16'h0001;
	localparam logic [LOW_W-1:0] STEP_WIDE = 16'h0002;
	localparam logic [PTR_W-1:0] ADDR_IRQ_ENABLE_LOW = 23'h000000;
	localparam logic [PTR_W-1:0] PTR_RESET = 23'h000000;
	localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

	typedef enum logic [1:0] {FORM_PLAIN, FORM_POST_INC, FORM_POST_DEC, FORM_PRE_INC} ipa_form_t;
	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_SECOND} ipa_st_t;

	typedef struct packed {
		ipa_st_t st;
		ipa_form_t form;
		logic wide;
		logic [SEL_W-1:0] sel;
		logic circ;
		logic [LOW_W-1:0] buf_start;
		logic [PTR_W-1:0] addr;
		logic addr_valid;
		logic addr_second;
		logic [PTR_W-1:0] second_addr;
		logic fault;
		logic ready;
		logic lag_valid;
		logic lag_second;
		logic [DATA_W-1:0] temp_two;
		logic [DATA_W-1:0] temp_three;
	} ipa_state_t;

	localparam ipa_state_t STATE_RESET = '{st: ST_IDLE, form: FORM_PLAIN, ready: 1'b1, default: '0};

	typedef struct packed {
		logic [NUM_PTRS-1:0][PTR_W-1:0] words;
		logic [PTR_W-1:0] rdata;
	} ipa_mem_state_t;

	// Word step for one access width
	function automatic logic [LOW_W-1:0] step_of(input logic wide);
		return wide ? STEP_WIDE : STEP_SHORT;
	endfunction

	// Partner word of a long access: even goes up one, odd goes down one
	function automatic logic [PTR_W-1:0] pair_of(input logic [PTR_W-1:0] a);
		return a[0] ? a - 23'h000001 : a + 23'h000001;
	endfunction
endpackage

// *** verilog/ipa_ptr_if.sv ***
// Interface between the address controller and its pointer store
`timescale 1ns/1ps
interface ipa_ptr_if;
	logic rd_en;
	logic [ipa_pkg::SEL_W-1:0] rd_sel;
	logic [ipa_pkg::PTR_W-1:0] rd_data;
	logic wr_en;
	logic [ipa_pkg::SEL_W-1:0] wr_sel;
	logic [ipa_pkg::PTR_W-1:0] wr_data;
	modport ctl (output rd_en, output rd_sel, input rd_data, output wr_en, output wr_sel, output wr_data);
	modport mem (input rd_en, input rd_sel, output rd_data, input wr_en, input wr_sel, input wr_data);
endinterface

// *** verilog/ipa_ptr_store.sv ***
// Store of extended pointers with registered read data
`timescale 1ns/1ps
module ipa_ptr_store (
	input wire logic clk_in,
	input wire logic arst_n_in,
	ipa_ptr_if.mem pif
);
	ipa_pkg::ipa_mem_state_t s_ff;
	ipa_pkg::ipa_mem_state_t nxt_s;

	// Write port and registered read port; a read in a write cycle sees old data
	always_comb begin
		nxt_s = s_ff;
		if (pif.wr_en) begin
			nxt_s.words[pif.wr_sel] = pif.wr_data;
		end
		if (pif.rd_en) begin
			nxt_s.rdata = s_ff.words[pif.rd_sel];
		end
	end

	// State register
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign pif.rd_data = s_ff.rdata;
endmodule
